// *** hcb_pkg.sv ***
// Function
// - Port 0/2 function comes from second config byte; changeable only in programming mode.
// - Ports default to GPIO; external access then leaves port values untouched.
// - External-access pin low at reset forces every later fetch external.
// - With ports enabled, fetches beyond internal program memory and outside the boot ROM window go external.
// - External mode dedicates Port 0, Port 2, P3.6, P3.7; Port 2 drives PC high byte.
// - Enabled boot ROM sits at F800-FFFF in user mode, first 2kB in programming mode.
// - Reset samples strobe and latch pins: 01 serial, 10 parallel, 11 user, 00 reserved.
// - Programming mode ends only through a reset with user-mode pin levels.
// - Flash and configuration bytes hold all ones when erased.
// - 128 config bytes writable only in programming mode, via address 93 and data 94.
// - Security set blocks config changes; only mass erase, clearing everything, changes them.
// - Security bit 7 low: after programming-mode reset, flash reachable only from application mode.
// - Program lock bit 6 overrides sector lock; high means read-only and no application writes.
// - Reset sector lock bit 5: low allows 4kB reset sector writes, high read-only.
// - Boot ROM enable bit 4: low disables, high enables.
// - Watchdog reset enable bit 3: low blocks watchdog resets, high allows them.
// - Data flash size bits 2-0: 000 reserved, 111 none, others give partition sizes.
// - Port 2/3 GPIO enable bit 0 low gives Port 2 and P3.6/P3.7 to external memory.
// - External memory routing only when both bit 0 and bit 1 are clear.
package hcb_pkg;
  localparam logic [7:0] SFR_CFG_ADDR = 8'h93;
  localparam logic [7:0] SFR_CFG_DATA = 8'h94;
  localparam int CFG_BYTES = 128;
  localparam logic [6:0] CFG_PORT_BOR = 7'h7E;
  localparam logic [6:0] CFG_SECURITY = 7'h7F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // Security byte fields
  localparam int SEC_BIT = 7;
  localparam int PML_BIT = 6;
  localparam int RSL_BIT = 5;
  localparam int EBR_BIT = 4;
  localparam int WATCHDOG_RESET_ENABLE_BIT = 3;
  localparam int DFS_LSB = 0;
  // Port and brownout byte fields
  localparam int DBL_LSB = 6;
  localparam int ABL_LSB = 4;
  localparam int DAB_BIT = 3;
  localparam int DDB_BIT = 2;
  localparam int PORT0_GPIO_ENABLE_BIT = 1;
  localparam int PORT2_3_GPIO_ENABLE_BIT = 0;
  localparam logic [2:0] DFS_RESERVED = 3'h0;
  localparam logic [2:0] DFS_NONE = 3'h7;
  localparam logic [1:0] BOR_4V5 = 2'h0;
  localparam logic [1:0] BOR_4V2 = 2'h1;
  localparam logic [1:0] BOR_2V7 = 2'h2;
  localparam logic [1:0] BOR_2V5 = 2'h3;
  // Boot ROM windows
  localparam logic [15:0] BOOT_USER_BASE = 16'hF800;
  localparam logic [15:0] BOOT_PROG_TOP = 16'h0800;
  localparam logic [16:0] INT_PROG_DEFAULT = 17'h08000;
  typedef enum logic [1:0] {MODE_USER, MODE_SERIAL, MODE_PARALLEL, MODE_RESERVED} hcb_mode_e;
  typedef struct packed {
    logic progAccess;
    logic progLock;
    logic rstSectLock;
    logic bootRomEn;
    logic wdtResetEn;
    logic [2:0] dfSize;
    logic [1:0] dbLevel;
    logic [1:0] abLevel;
    logic abDisable;
    logic dbDisable;
    logic p0Gpio;
    logic p23Gpio;
  } hcb_cfg_s;
endpackage

// *** hcb_config_boot.sv ***
`timescale 1ns/1ps
module hcb_config_boot #(
  parameter logic [16:0] INT_PROG_SIZE = hcb_pkg::INT_PROG_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic strobePin,
  input wire logic latchPin,
  input wire logic externalAccessPin_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  input wire logic massErase,
  input wire logic uamActive,
  input wire logic wdtResetReq,
  input wire logic [15:0] pc,
  input wire logic progFetch,
  input wire logic [7:0] busP0,
  input wire logic busP0Oe,
  input wire logic [7:0] busP2,
  input wire logic busWr_n,
  input wire logic busRd_n,
  input wire logic [7:0] gpioP0,
  input wire logic gpioP0Oe,
  input wire logic [7:0] gpioP2,
  input wire logic [1:0] gpioP3Hi,
  output logic [7:0] port0Out,
  output logic port0Oe,
  output logic [7:0] port2Out,
  output logic [1:0] port3Hi,
  output hcb_pkg::hcb_mode_e mode,
  output logic progMode,
  output hcb_pkg::hcb_cfg_s cfgOut,
  output logic extMemEn,
  output logic fetchExternal,
  output logic bootRomSel,
  output logic flashAccessOk,
  output logic progWriteOk,
  output logic progReadOk,
  output logic resetSectorWriteOk,
  output logic wdtResetOut,
  output logic dfReserved,
  output logic analogBorEn,
  output logic digitalBorEn
);
  // Strap decode, shared by the latch and its check
  function automatic hcb_pkg::hcb_mode_e strapMode(input logic strobe, input logic latchEn);
    unique case ({strobe, latchEn})
      2'b01: strapMode = hcb_pkg::MODE_SERIAL;
      2'b10: strapMode = hcb_pkg::MODE_PARALLEL;
      2'b11: strapMode = hcb_pkg::MODE_USER;
      2'b00: strapMode = hcb_pkg::MODE_RESERVED;
    endcase
  endfunction

  // Field split of the two control bytes
  function automatic hcb_pkg::hcb_cfg_s unpackCfg(input logic [7:0] sec, input logic [7:0] prt);
    hcb_pkg::hcb_cfg_s c;
    c.progAccess = sec[hcb_pkg::SEC_BIT];
    c.progLock = sec[hcb_pkg::PML_BIT];
    c.rstSectLock = sec[hcb_pkg::RSL_BIT];
    c.bootRomEn = sec[hcb_pkg::EBR_BIT];
    c.wdtResetEn = sec[hcb_pkg::WATCHDOG_RESET_ENABLE_BIT];
    c.dfSize = sec[hcb_pkg::DFS_LSB +: 3];
    c.dbLevel = prt[hcb_pkg::DBL_LSB +: 2];
    c.abLevel = prt[hcb_pkg::ABL_LSB +: 2];
    c.abDisable = prt[hcb_pkg::DAB_BIT];
    c.dbDisable = prt[hcb_pkg::DDB_BIT];
    c.p0Gpio = prt[hcb_pkg::PORT0_GPIO_ENABLE_BIT];
    c.p23Gpio = prt[hcb_pkg::PORT2_3_GPIO_ENABLE_BIT];
    return c;
  endfunction

  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] syncC;
  logic [2:0] pinStable;
  logic extOnly;
  logic [6:0] addrReg;
  // Nonvolatile bytes start erased; reset must not touch them
  logic [7:0] cfgMem [hcb_pkg::CFG_BYTES] = '{default: hcb_pkg::ERASED_BYTE};
  logic [7:0] tgtByte;
  logic secured;
  logic cfgWrite;
  logic beyondInternal;

  // Pins are asynchronous; a change counts once the last two stages agree
  always_ff @(posedge ref_clk) begin
    syncA <= {strobePin, latchPin, externalAccessPin_n};
    syncB <= syncA;
    syncC <= syncB;
  end

  for (genvar i = 0; i < 3; i++) begin : g_filt
    always_ff @(posedge ref_clk) begin
      if (syncB[i] == syncC[i]) begin
        pinStable[i] <= syncC[i];
      end
    end
  end

  // Straps are caught on every edge while reset is held, then frozen
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode <= strapMode(pinStable[2], pinStable[1]);
    end
  end

  // Access pin low during reset makes every fetch external until next reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      extOnly <= ~pinStable[0];
    end
  end

  assign progMode = (mode == hcb_pkg::MODE_SERIAL) || (mode == hcb_pkg::MODE_PARALLEL);

  // Address register selects one of the 128 bytes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addrReg <= '0;
    end else if (sfrWr && sfrAddr == hcb_pkg::SFR_CFG_ADDR) begin
      addrReg <= sfrWrData[6:0];
    end
  end

  assign tgtByte = cfgMem[addrReg];
  assign secured = ~cfgMem[hcb_pkg::CFG_SECURITY][hcb_pkg::SEC_BIT];
  assign cfgWrite = sfrWr && sfrAddr == hcb_pkg::SFR_CFG_DATA && progMode && !secured;

  // Mass erase beats any write and is the only way past the security bit
  always_ff @(posedge ref_clk) begin
    if (massErase && progMode) begin
      for (int k = 0; k < hcb_pkg::CFG_BYTES; k++) begin
        cfgMem[k] <= hcb_pkg::ERASED_BYTE;
      end
    end else if (cfgWrite) begin
      cfgMem[addrReg] <= sfrWrData;
    end
  end

  // Read data is registered; unmapped addresses return zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sfrRdData <= hcb_pkg::RD_ZERO;
    end else if (sfrRd) begin
      if (sfrAddr == hcb_pkg::SFR_CFG_DATA) begin
        sfrRdData <= tgtByte;
      end else if (sfrAddr == hcb_pkg::SFR_CFG_ADDR) begin
        sfrRdData <= {1'b0, addrReg};
      end else begin
        sfrRdData <= hcb_pkg::RD_ZERO;
      end
    end
  end

  // Decoded view lags the array by one edge; erased value is the default
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfgOut <= unpackCfg(hcb_pkg::ERASED_BYTE, hcb_pkg::ERASED_BYTE);
    end else begin
      cfgOut <= unpackCfg(cfgMem[hcb_pkg::CFG_SECURITY], cfgMem[hcb_pkg::CFG_PORT_BOR]);
    end
  end

  // Lock and enable decode
  assign flashAccessOk = !(progMode && !cfgOut.progAccess) || uamActive;
  assign progReadOk = flashAccessOk;
  assign progWriteOk = flashAccessOk && !cfgOut.progLock;
  assign resetSectorWriteOk = progWriteOk && !cfgOut.rstSectLock;
  assign wdtResetOut = wdtResetReq && cfgOut.wdtResetEn;
  assign dfReserved = cfgOut.dfSize == hcb_pkg::DFS_RESERVED;
  assign analogBorEn = !cfgOut.abDisable;
  assign digitalBorEn = !cfgOut.dbDisable;

  // External bus needs both GPIO enables cleared
  assign extMemEn = !cfgOut.p0Gpio && !cfgOut.p23Gpio;

  // Boot ROM window depends on mode; in programming mode it covers the first 2kB whatever the enable bit
  always_comb begin
    if (progMode) begin
      bootRomSel = pc < hcb_pkg::BOOT_PROG_TOP;
    end else begin
      bootRomSel = cfgOut.bootRomEn && pc >= hcb_pkg::BOOT_USER_BASE;
    end
  end

  assign beyondInternal = {1'b0, pc} >= INT_PROG_SIZE;
  assign fetchExternal = extOnly || (extMemEn && beyondInternal && !bootRomSel);

  // Port drivers are registered; GPIO owners keep the pins otherwise
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port0Out <= hcb_pkg::ERASED_BYTE;
      port0Oe <= 1'b0;
    end else if (extMemEn) begin
      port0Out <= busP0;
      port0Oe <= busP0Oe;
    end else begin
      port0Out <= gpioP0;
      port0Oe <= gpioP0Oe;
    end
  end

  // Port 2 carries the PC high byte on program fetches when the external bus is enabled
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port2Out <= hcb_pkg::ERASED_BYTE;
    end else if (extMemEn && progFetch) begin
      port2Out <= pc[15:8];
    end else if (extMemEn) begin
      port2Out <= busP2;
    end else begin
      port2Out <= gpioP2;
    end
  end

  // P3.7 read strobe, P3.6 write strobe in external mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port3Hi <= 2'h3;
    end else if (extMemEn) begin
      port3Hi <= {busRd_n, busWr_n};
    end else begin
      port3Hi <= gpioP3Hi;
    end
  end

  // Checks
  sequence s_addr_set;
    sfrWr && sfrAddr == hcb_pkg::SFR_CFG_ADDR;
  endsequence

  sequence s_data_read;
    sfrRd && !sfrWr && !massErase && sfrAddr == hcb_pkg::SFR_CFG_DATA;
  endsequence

  a_read_selected: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_addr_set ##1 s_data_read |=> sfrRdData == cfgMem[$past(sfrWrData[6:0], 2)])
    else $error("config data read returned wrong byte");

  a_user_write_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sfrWr && sfrAddr == hcb_pkg::SFR_CFG_DATA && !progMode |=> $stable(tgtByte))
    else $error("config byte changed outside programming mode");

  a_secure_write_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sfrWr && sfrAddr == hcb_pkg::SFR_CFG_DATA && secured && !massErase |=> $stable(tgtByte))
    else $error("config byte changed while secured");

  a_erase_ones: assert property (@(posedge ref_clk) disable iff (sys_rst)
    massErase && progMode |=> tgtByte == hcb_pkg::ERASED_BYTE ##1 cfgOut.progAccess && cfgOut.p0Gpio)
    else $error("mass erase did not leave all ones");

  a_strap_decode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> mode == strapMode($past(pinStable[2]), $past(pinStable[1])))
    else $error("strap mode decoded wrongly");

  a_mode_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(mode) && $stable(extOnly))
    else $error("mode changed without reset");

  a_ext_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
    extOnly |-> fetchExternal)
    else $error("fetch not external with access pin low");

  a_gpio_fetch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !extOnly && !extMemEn |-> !fetchExternal)
    else $error("external fetch with ports in GPIO");

  a_gpio_ports: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !extMemEn |=> port0Out == $past(gpioP0) && port2Out == $past(gpioP2))
    else $error("GPIO port value disturbed");

  a_pc_high_byte: assert property (@(posedge ref_clk) disable iff (sys_rst)
    extMemEn && progFetch |=> port2Out == $past(pc[15:8]))
    else $error("Port 2 not carrying PC high byte");

  a_boot_window: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !progMode && !cfgOut.bootRomEn |-> !bootRomSel)
    else $error("disabled boot ROM selected in user mode");

  a_lock_priority: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfgOut.progLock |-> !resetSectorWriteOk && !progWriteOk)
    else $error("program lock did not override sector lock");

  a_addr_capture: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_addr_set |=> addrReg == $past(sfrWrData[6:0]))
    else $error("config address not captured");

  a_port_strobes: assert property (@(posedge ref_clk) disable iff (sys_rst)
    extMemEn |=> port3Hi == $past({busRd_n, busWr_n}))
    else $error("P3.6/P3.7 not carrying bus strobes");

  a_prog_boot: assert property (@(posedge ref_clk) disable iff (sys_rst)
    progMode && pc < hcb_pkg::BOOT_PROG_TOP |-> bootRomSel)
    else $error("boot ROM missing low in programming mode");

  a_wdt_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !cfgOut.wdtResetEn |-> !wdtResetOut)
    else $error("watchdog reset passed while disabled");
endmodule

// *** hcb_strap_partner.sv ***
`timescale 1ns/1ps
module hcb_strap_partner (
  input wire logic sys_rst,
  input wire logic [1:0] reqMode,
  input wire logic reqExtOnly,
  output logic strobePin,
  output logic latchPin,
  output logic externalAccessPin_n
);
  // Straps are presented only while reset is high; pull-ups restore high after release
  // A both-low request is shown as user levels, never as the reserved code
  // After release the pins sit at normal-mode levels, so a new reset is the only way out
  assign strobePin = sys_rst ? (reqMode[1] | ~reqMode[0]) : 1'b1;
  assign latchPin = sys_rst ? (reqMode[0] | ~reqMode[1]) : 1'b1;
  // The access pin is board wiring, so it holds its level at all times
  assign externalAccessPin_n = ~reqExtOnly;
endmodule

// *** hcb_config_boot_bench.sv ***
`timescale 1ns/1ps
module hcb_config_boot_bench;
  localparam logic [16:0] INT_SIZE = 17'h02000;
  localparam logic [7:0] CA = hcb_pkg::SFR_CFG_ADDR;
  localparam logic [7:0] CD = hcb_pkg::SFR_CFG_DATA;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reqMode = 2'h3;
  logic reqExtOnly = 1'b0;
  logic strobePin, latchPin, externalAccessPin_n;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
  logic sfrWr = 1'b0, sfrRd = 1'b0, massErase = 1'b0, uamActive = 1'b0, wdtResetReq = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic progFetch = 1'b0, busP0Oe = 1'b0, busWr_n = 1'b1, busRd_n = 1'b1, gpioP0Oe = 1'b0;
  logic [7:0] busP0 = 8'h00, busP2 = 8'h00, gpioP0 = 8'h00, gpioP2 = 8'h00, port0Out, port2Out;
  logic [1:0] gpioP3Hi = 2'h3, port3Hi;
  logic port0Oe, progMode, extMemEn, fetchExternal, bootRomSel, flashAccessOk, progWriteOk;
  logic progReadOk, resetSectorWriteOk, wdtResetOut, dfReserved, analogBorEn, digitalBorEn;
  logic rdLast = 1'b0;
  hcb_pkg::hcb_mode_e mode;
  hcb_pkg::hcb_cfg_s cfgOut;
  logic [7:0] rdQ[$];
  int errors = 0;
  int checks = 0;
  int seed = 78;

  hcb_strap_partner hcb_strap_partner_i (.sys_rst, .reqMode, .reqExtOnly, .strobePin, .latchPin,
    .externalAccessPin_n);
  hcb_config_boot #(.INT_PROG_SIZE(INT_SIZE)) hcb_config_boot_i (.ref_clk, .sys_rst, .strobePin,
    .latchPin, .externalAccessPin_n, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .massErase,
    .uamActive, .wdtResetReq, .pc, .progFetch, .busP0, .busP0Oe, .busP2, .busWr_n, .busRd_n, .gpioP0,
    .gpioP0Oe, .gpioP2, .gpioP3Hi, .port0Out, .port0Oe, .port2Out, .port3Hi, .mode, .progMode, .cfgOut,
    .extMemEn, .fetchExternal, .bootRomSel, .flashAccessOk, .progWriteOk, .progReadOk,
    .resetSectorWriteOk, .wdtResetOut, .dfReserved, .analogBorEn, .digitalBorEn);

  // Free-running 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One bus request per cycle, changed only at the falling edge
  task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfrWr = wr;
    sfrRd = rd;
    sfrAddr = a;
    sfrWrData = d;
  endtask

  task automatic sfrR(input logic [7:0] a, input logic [7:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic doReset(input logic [1:0] m, input logic x);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    reqMode = m;
    reqExtOnly = x;
    sys_rst = 1'b1;
    cyc(10);
    sys_rst = 1'b0;
    cyc(2);
  endtask

  // Read data is due one edge after the read edge; oldest note is compared
  always @(posedge ref_clk) rdLast <= sfrRd;
  always @(negedge ref_clk) begin
    if (rdLast) begin
      if (rdQ.size() == 0)
        chk(17'h10000, 17'h00000);
      else
        chk(sfrRdData, rdQ.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  initial begin
    doReset(2'h3, 1'b0);
    chk(mode, hcb_pkg::MODE_USER);
    chk(progMode, 1'b0);
    chk(cfgOut, 16'hFFFF);
    bus(1'b1, 1'b0, CA, 8'h7E);
    sfrR(CA, 8'h7E);
    sfrR(CD, hcb_pkg::ERASED_BYTE);
    bus(1'b1, 1'b0, CD, 8'h00);
    sfrR(CD, hcb_pkg::ERASED_BYTE);
    sfrR(8'h95, hcb_pkg::RD_ZERO);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    gpioP0 = 8'($random(seed));
    gpioP2 = 8'($random(seed));
    busP0 = ~gpioP0;
    busP2 = ~gpioP2;
    pc = 16'hF800;
    wdtResetReq = 1'b1;
    cyc(2);
    chk({port0Out, port2Out}, {gpioP0, gpioP2});
    chk(extMemEn, 1'b0);
    chk(bootRomSel, 1'b1);
    chk(wdtResetOut, 1'b1);
    chk({analogBorEn, digitalBorEn, dfReserved}, 3'h0);
    pc = 16'hF7FF;
    cyc(1);
    chk(bootRomSel, 1'b0);
    $display("user defaults done");

    doReset(2'h1, 1'b0);
    chk(mode, hcb_pkg::MODE_SERIAL);
    chk(progMode, 1'b1);
    pc = 16'h0000;
    cyc(1);
    chk(bootRomSel, 1'b1);
    bus(1'b1, 1'b0, CA, 8'h7E);
    bus(1'b1, 1'b0, CD, 8'h51);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    cyc(2);
    chk(extMemEn, 1'b0);
    bus(1'b1, 1'b0, CD, 8'h50);
    sfrR(CD, 8'h50);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    cyc(2);
    chk(extMemEn, 1'b1);
    chk({cfgOut.dbLevel, cfgOut.abLevel}, {hcb_pkg::BOR_4V2, hcb_pkg::BOR_4V2});
    chk({analogBorEn, digitalBorEn}, 2'h3);
    pc = 16'($random(seed));
    busP0 = 8'($random(seed));
    busP2 = ~pc[15:8];
    busWr_n = 1'b0;
    busP0Oe = 1'b1;
    progFetch = 1'b1;
    cyc(2);
    chk({port0Out, port2Out}, {busP0, pc[15:8]});
    chk({port3Hi, port0Oe}, 3'h5);
    progFetch = 1'b0;
    cyc(1);
    chk(port2Out, busP2);
    $display("serial mode ports done");

    bus(1'b1, 1'b0, CA, 8'h7F);
    bus(1'b1, 1'b0, CD, 8'h60);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    cyc(2);
    chk(cfgOut.bootRomEn, 1'b0);
    chk(dfReserved, 1'b1);
    chk(wdtResetOut, 1'b0);
    chk({flashAccessOk, progReadOk}, 2'h0);
    uamActive = 1'b1;
    cyc(1);
    chk({flashAccessOk, progWriteOk, progReadOk}, 3'h5);
    uamActive = 1'b0;
    bus(1'b1, 1'b0, CD, 8'hFF);
    sfrR(CD, 8'h60);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    massErase = 1'b1;
    cyc(1);
    massErase = 1'b0;
    sfrR(CD, hcb_pkg::ERASED_BYTE);
    bus(1'b1, 1'b0, CA, 8'h7E);
    sfrR(CD, hcb_pkg::ERASED_BYTE);
    bus(1'b1, 1'b0, CD, 8'hFC);
    bus(1'b1, 1'b0, CA, 8'h7F);
    bus(1'b1, 1'b0, CD, 8'h9F);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    cyc(2);
    chk({progWriteOk, resetSectorWriteOk}, 2'h3);
    bus(1'b1, 1'b0, CD, 8'hBF);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    cyc(2);
    chk({progWriteOk, resetSectorWriteOk}, 2'h2);
    $display("security and erase done");

    doReset(2'h2, 1'b0);
    chk(mode, hcb_pkg::MODE_PARALLEL);
    doReset(2'h3, 1'b0);
    chk({mode, extMemEn}, {hcb_pkg::MODE_USER, 1'b1});
    bus(1'b1, 1'b0, CA, 8'h7E);
    bus(1'b1, 1'b0, CD, 8'h03);
    sfrR(CD, 8'hFC);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    pc = INT_SIZE[15:0];
    cyc(1);
    chk(fetchExternal, 1'b1);
    pc = INT_SIZE[15:0] - 16'h0001;
    cyc(1);
    chk(fetchExternal, 1'b0);
    pc = hcb_pkg::BOOT_USER_BASE;
    cyc(1);
    chk(bootRomSel, 1'b1);
    doReset(2'h3, 1'b1);
    pc = 16'h0000;
    cyc(1);
    chk(fetchExternal, 1'b1);
    $display("mode exit and fetch routing done");
    summarize();
  end
endmodule
